// *** hw/acc_dev.sv ***
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
module acc_dev
	import acc_pkg::*;
#(
	parameter int         DW            = 12,
	parameter int         FG_CAL_CYCLES = ACC_FG_CAL_CYC,
	parameter int         BG_CAL_CYCLES = ACC_BG_CAL_CYC,
	parameter logic [7:0] OFS_DEFAULT   = ACC_TRIM_DEFAULT,
	parameter logic [7:0] GAIN_DEFAULT  = ACC_TRIM_DEFAULT,
	parameter logic [7:0] TERM_DEFAULT  = ACC_TRIM_DEFAULT
)(
	input  wire logic                               ref_clk,
	input  wire logic                               reset,
	acc_link_if.dev                                 link,
	input  wire logic [ACC_NUM_CORES-1:0][DW-1:0]   core_sample,
	output logic      [ACC_NUM_CHANS-1:0][DW-1:0]   chan_data,
	output logic      [ACC_NUM_CORES-1:0]           core_sampling,
	output logic      [ACC_NUM_CORES-1:0]           core_in_cal,
	output logic                                    fg_offset_correction,
	output logic                                    bg_offset_correction,
	output logic                                    cal_busy
);
	typedef enum logic [2:0] {ST_FG, ST_IDLE, ST_BG_CAL, ST_SWAP_SRC, ST_SWAP_MUX} acc_state_t;

	acc_state_t  state_q;
	logic [15:0] cnt_q;
	logic [2:0]  phase_q;
	logic [2:0]  src_phase_q;
	logic [2:0]  mux_phase_q;
	logic [7:0]  cal_ctrl_q;
	logic [7:0]  trig_q;
	logic [7:0]  swap_src_q;
	logic [7:0]  swap_mux_q;
	logic [7:0]  ofs_trim_q  [ACC_NUM_CORES];
	logic [7:0]  gain_trim_q [ACC_NUM_CORES];
	logic [7:0]  term_trim_q [ACC_NUM_CHANS];
	logic        fg_done_q;
	logic        pin_s1_q;
	logic        pin_s2_q;
	logic        trig_prev_q;
	logic [7:0]  rdata_q;

	// Phase order: cores 2,0,1 in bank A, then 3,4,5 in bank B
	function automatic logic [2:0] cal_core(input logic [2:0] ph);
		case (ph)
			3'h0:    cal_core = 3'h2;
			3'h1:    cal_core = 3'h0;
			3'h2:    cal_core = 3'h1;
			3'h3:    cal_core = 3'h3;
			3'h4:    cal_core = 3'h4;
			default: cal_core = 3'h5;
		endcase
	endfunction

	// Offline core per bank; idle bank rests with its spare out
	function automatic logic [5:0] offline_set(input logic [2:0] ph);
		logic [2:0] off_a;
		logic [2:0] off_b;
		off_a = (ph < 3'h3) ? cal_core(ph) : 3'h2;
		off_b = (ph >= 3'h3) ? cal_core(ph) : 3'h3;
		offline_set = (6'h01 << off_a) | (6'h01 << off_b);
	endfunction

	// Core feeding a channel: spare stands in for the offline core
	function automatic logic [2:0] chan_core(input int ch, input logic [5:0] offl);
		logic [2:0] home;
		logic [2:0] spare;
		home  = (ch < 2) ? 3'(ch) : 3'(ch + 2);
		spare = (ch < 2) ? 3'h2 : 3'h3;
		chan_core = offl[home] ? spare : home;
	endfunction

	// Trigger source: pin passes two flops first
	wire       trig_src   = trig_q[ACC_BIT_TRIG_SEL] ? pin_s2_q : trig_q[ACC_BIT_SOFT_TRIG];
	wire       trig_rise  = trig_src & ~trig_prev_q;
	wire       bg_en      = cal_ctrl_q[ACC_BIT_BG_EN];
	wire       bg_run     = bg_en & trig_src & ~trig_q[ACC_BIT_TRIG_SEL];
	wire       fg_start   = (state_q == ST_IDLE) & trig_rise & ~bg_en;
	wire       bg_start   = (state_q == ST_IDLE) & bg_run;
	wire       cnt_zero   = (cnt_q == 16'h0000);
	wire [2:0] next_phase = (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
	wire       fg_active  = (state_q == ST_FG);
	wire       fg_end     = fg_active & cnt_zero;
	wire       bg_cal_end = (state_q == ST_BG_CAL) & cnt_zero & bg_run;
	wire [5:0] mux_offl   = offline_set(mux_phase_q);
	wire [5:0] src_offl   = offline_set(src_phase_q);

	// Register decode
	wire       wr       = link.reg_wr;
	wire [7:0] addr     = link.reg_addr;
	wire       ofs_hit  = (addr >= ACC_REG_OFS_BASE) && (addr < ACC_REG_OFS_BASE + 8'(ACC_NUM_CORES));
	wire       gain_hit = (addr >= ACC_REG_GAIN_BASE) && (addr < ACC_REG_GAIN_BASE + 8'(ACC_NUM_CORES));
	wire       term_hit = (addr >= ACC_REG_TERM_BASE) && (addr < ACC_REG_TERM_BASE + 8'(ACC_NUM_CHANS));
	wire [2:0] ofs_idx  = 3'(addr - ACC_REG_OFS_BASE);
	wire [2:0] gain_idx = 3'(addr - ACC_REG_GAIN_BASE);
	wire [1:0] term_idx = 2'(addr - ACC_REG_TERM_BASE);
	wire [7:0] status_val;
	wire [7:0] rd_val;

	assign status_val = {1'b0, cal_core(phase_q), 1'b0, (state_q != ST_FG) && (state_q != ST_IDLE),
		fg_active, fg_done_q};
	assign rd_val = (addr == ACC_REG_CAL_CTRL) ? cal_ctrl_q :
		(addr == ACC_REG_TRIG)     ? trig_q :
		(addr == ACC_REG_STATUS)   ? status_val :
		(addr == ACC_REG_SWAP_SRC) ? swap_src_q :
		(addr == ACC_REG_SWAP_MUX) ? swap_mux_q :
		ofs_hit  ? ofs_trim_q[ofs_idx] :
		gain_hit ? gain_trim_q[gain_idx] :
		term_hit ? term_trim_q[term_idx] : 8'h00;

	// Pin synchroniser and edge memory
	always_ff @(posedge ref_clk)
	begin
		pin_s1_q    <= reset ? 1'b0 : link.external_cal_trigger_pin;
		pin_s2_q    <= reset ? 1'b0 : pin_s1_q;
		trig_prev_q <= reset ? 1'b0 : trig_src;
	end

	// Control registers; read data one cycle later
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			cal_ctrl_q <= ACC_RST_CAL_CTRL;
			trig_q     <= ACC_RST_TRIG;
			swap_src_q <= ACC_RST_SWAP;
			swap_mux_q <= ACC_RST_SWAP;
			rdata_q    <= 8'h00;
		end
		else
		begin
			if (wr && addr == ACC_REG_CAL_CTRL)
				cal_ctrl_q <= link.reg_wdata & 8'h07;
			if (wr && addr == ACC_REG_TRIG)
				trig_q <= link.reg_wdata & 8'h03;
			if (wr && addr == ACC_REG_SWAP_SRC)
				swap_src_q <= link.reg_wdata;
			if (wr && addr == ACC_REG_SWAP_MUX)
				swap_mux_q <= link.reg_wdata;
			rdata_q <= link.reg_rd ? rd_val : 8'h00;
		end
	end
	assign link.reg_rdata = rdata_q;

	// Trim banks, loaded with factory values at reset
	generate
		for (genvar c = 0; c < ACC_NUM_CORES; c++)
		begin : g_core_trim
			always_ff @(posedge ref_clk)
			begin
				if (reset)
				begin
					ofs_trim_q[c]  <= OFS_DEFAULT;
					gain_trim_q[c] <= GAIN_DEFAULT;
				end
				else
				begin
					if (wr && ofs_hit && ofs_idx == 3'(c))
						ofs_trim_q[c] <= link.reg_wdata;
					if (wr && gain_hit && gain_idx == 3'(c))
						gain_trim_q[c] <= link.reg_wdata;
				end
			end
		end
		for (genvar t = 0; t < ACC_NUM_CHANS; t++)
		begin : g_term_trim
			always_ff @(posedge ref_clk)
			begin
				if (reset)
					term_trim_q[t] <= TERM_DEFAULT;
				else if (wr && term_hit && term_idx == 2'(t))
					term_trim_q[t] <= link.reg_wdata;
			end
		end
	endgenerate

	// Calibration sequencer; reset counts as power-up
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_q     <= ST_FG;
			cnt_q       <= 16'(FG_CAL_CYCLES - 1);
			phase_q     <= 3'h0;
			src_phase_q <= 3'h0;
			mux_phase_q <= 3'h0;
			fg_done_q   <= 1'b0;
		end
		else
		begin
			case (state_q)
				ST_FG:
				begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_zero)
					begin
						state_q   <= ST_IDLE;
						fg_done_q <= 1'b1;
					end
				end
				ST_IDLE:
				begin
					if (bg_start)
					begin
						state_q <= ST_BG_CAL;
						cnt_q   <= 16'(BG_CAL_CYCLES - 1);
					end
					else if (fg_start)
					begin
						state_q   <= ST_FG;
						cnt_q     <= 16'(FG_CAL_CYCLES - 1);
						fg_done_q <= 1'b0;
					end
				end
				ST_BG_CAL:
				begin
					// One core at a time; leaving restores the home layout
					cnt_q <= cnt_q - 16'h0001;
					if (!bg_run)
					begin
						state_q     <= ST_IDLE;
						phase_q     <= 3'h0;
						src_phase_q <= 3'h0;
						mux_phase_q <= 3'h0;
					end
					else if (cnt_zero)
					begin
						state_q <= ST_SWAP_SRC;
						cnt_q   <= {8'h00, swap_src_q};
					end
				end
				ST_SWAP_SRC:
				begin
					// New core starts sampling before the mux moves
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_zero)
					begin
						src_phase_q <= next_phase;
						state_q     <= ST_SWAP_MUX;
						cnt_q       <= {8'h00, swap_mux_q};
					end
				end
				ST_SWAP_MUX:
				begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_zero)
					begin
						mux_phase_q <= next_phase;
						phase_q     <= next_phase;
						state_q     <= ST_BG_CAL;
						cnt_q       <= 16'(BG_CAL_CYCLES - 1);
					end
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Offset correction strobes: once per foreground run, each background core
	always_ff @(posedge ref_clk)
	begin
		fg_offset_correction <= reset ? 1'b0 : fg_end & cal_ctrl_q[ACC_BIT_FG_OFS];
		bg_offset_correction <= reset ? 1'b0 : bg_cal_end & cal_ctrl_q[ACC_BIT_BG_OFS];
	end

	// Core activity: both old and new core sample during a swap
	always_ff @(posedge ref_clk)
	begin
		core_sampling <= reset ? 6'h00 : fg_active ? 6'h00 : ~(src_offl & mux_offl);
		core_in_cal   <= reset ? 6'h3F : fg_active ? 6'h3F :
			(state_q == ST_BG_CAL) ? 6'(6'h01 << cal_core(phase_q)) : 6'h00;
		cal_busy      <= reset ? 1'b1 : fg_active;
	end

	// Channel data: mid-code while foreground calibration runs
	generate
		for (genvar ch = 0; ch < ACC_NUM_CHANS; ch++)
		begin : g_chan
			always_ff @(posedge ref_clk)
			begin
				if (reset || fg_active)
					chan_data[ch] <= DW'(ACC_MID_CODE);
				else
					chan_data[ch] <= core_sample[chan_core(ch, mux_offl)];
			end
		end
	endgenerate
endmodule

// *** hw/acc_pkg.sv ***
package acc_pkg;
	localparam int          ACC_NUM_CORES    = 6;
	localparam int          ACC_NUM_CHANS    = 4;
	localparam int          ACC_CLK_MHZ      = 100;
	// Calibration run times, in microseconds
	localparam int          ACC_FG_CAL_US    = 10;
	localparam int          ACC_BG_CAL_US    = 5;
	localparam int          ACC_HOST_WAIT_US = 12;
	localparam int          ACC_FG_CAL_CYC   = ACC_FG_CAL_US * ACC_CLK_MHZ;
	localparam int          ACC_BG_CAL_CYC   = ACC_BG_CAL_US * ACC_CLK_MHZ;
	localparam int          ACC_HOST_WAIT_CYC = ACC_HOST_WAIT_US * ACC_CLK_MHZ;
	// Device register map
	localparam logic [7:0]  ACC_REG_CAL_CTRL = 8'h60;
	localparam logic [7:0]  ACC_REG_TRIG     = 8'h61;
	localparam logic [7:0]  ACC_REG_STATUS   = 8'h62;
	localparam logic [7:0]  ACC_REG_OFS_BASE = 8'h70;
	localparam logic [7:0]  ACC_REG_GAIN_BASE = 8'h78;
	localparam logic [7:0]  ACC_REG_TERM_BASE = 8'h80;
	localparam logic [7:0]  ACC_REG_SWAP_SRC = 8'h9A;
	localparam logic [7:0]  ACC_REG_SWAP_MUX = 8'h9B;
	// Host local register map
	localparam logic [7:0]  ACC_HREG_PIN     = 8'hF0;
	localparam logic [7:0]  ACC_HREG_CMD     = 8'hF1;
	localparam logic [7:0]  ACC_HREG_STATUS  = 8'hF2;
	// Field positions
	localparam int          ACC_BIT_BG_EN    = 0;
	localparam int          ACC_BIT_FG_OFS   = 1;
	localparam int          ACC_BIT_BG_OFS   = 2;
	localparam int          ACC_BIT_TRIG_SEL = 0;
	localparam int          ACC_BIT_SOFT_TRIG = 1;
	localparam int          ACC_BIT_FG_DONE  = 0;
	localparam int          ACC_BIT_FG_BUSY  = 1;
	localparam int          ACC_BIT_BG_RUN   = 2;
	localparam int          ACC_BIT_CAL_CORE = 4;
	localparam int          ACC_BIT_CMD_BG   = 0;
	localparam int          ACC_BIT_CMD_SWAP = 1;
	// Reset and recommended values
	localparam logic [7:0]  ACC_RST_CAL_CTRL = 8'h00;
	localparam logic [7:0]  ACC_RST_TRIG     = 8'h00;
	localparam logic [7:0]  ACC_RST_SWAP     = 8'h00;
	localparam logic [7:0]  ACC_TRIM_DEFAULT = 8'h80;
	localparam logic [7:0]  ACC_REC_SWAP_SRC = 8'h1F;
	localparam logic [7:0]  ACC_REC_SWAP_MUX = 8'h1E;
	localparam logic [7:0]  ACC_BG_TRIG_VAL  = 8'h02;
	localparam logic [7:0]  ACC_BG_CTRL_VAL  = 8'h01;
	localparam logic [11:0] ACC_MID_CODE     = 12'h000;
endpackage

// *** hw/acc_link_if.sv ***
`timescale 1ns/10ps
// Register port and trigger pin between system controller and device
interface acc_link_if;
	logic       external_cal_trigger_pin;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	modport dev  (input external_cal_trigger_pin, reg_addr, reg_wdata, reg_wr, reg_rd, output reg_rdata);
	modport host (output external_cal_trigger_pin, reg_addr, reg_wdata, reg_wr, reg_rd, input reg_rdata);
endinterface

// *** hw/acc_host.sv ***
`timescale 1ns/10ps
module acc_host
	import acc_pkg::*;
#(
	parameter int WAIT_CYCLES = ACC_HOST_WAIT_CYC
)(
	input  wire logic       ref_clk,
	input  wire logic       reset,
	acc_link_if.host        link,
	input  wire logic [7:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_wr,
	input  wire logic       sw_rd,
	output logic      [7:0] sw_rdata,
	output logic            host_ready
);
	logic [15:0] wait_q;
	logic        ready_q;
	logic        pin_q;
	logic        seq_busy_q;
	logic [1:0]  seq_idx_q;
	logic [1:0]  seq_end_q;
	logic        loc_rd_q;
	logic [7:0]  loc_rdata_q;

	// Fixed write sequences: swap delays, then background start
	function automatic logic [15:0] seq_step(input logic [1:0] i);
		case (i)
			2'h0:    seq_step = {ACC_REG_SWAP_SRC, ACC_REC_SWAP_SRC};
			2'h1:    seq_step = {ACC_REG_SWAP_MUX, ACC_REC_SWAP_MUX};
			2'h2:    seq_step = {ACC_REG_CAL_CTRL, ACC_BG_CTRL_VAL};
			default: seq_step = {ACC_REG_TRIG, ACC_BG_TRIG_VAL};
		endcase
	endfunction

	// Device accesses pass only after the power-up wait and outside sequences
	wire        local_hit = (sw_addr >= ACC_HREG_PIN);
	wire        fwd       = ready_q & ~seq_busy_q & ~local_hit;
	wire [15:0] step      = seq_step(seq_idx_q);
	wire        cmd_wr    = ready_q & ~seq_busy_q & sw_wr & (sw_addr == ACC_HREG_CMD);
	wire        wait_done = (wait_q == 16'h0000);
	wire [7:0]  loc_val   = (sw_addr == ACC_HREG_PIN) ? {7'h00, pin_q} :
		(sw_addr == ACC_HREG_STATUS) ? {6'h00, seq_busy_q, ready_q} : 8'h00;

	assign link.external_cal_trigger_pin = pin_q;
	assign link.reg_addr  = seq_busy_q ? step[15:8] : sw_addr;
	assign link.reg_wdata = seq_busy_q ? step[7:0] : sw_wdata;
	assign link.reg_wr    = seq_busy_q | (fwd & sw_wr);
	assign link.reg_rd    = ~seq_busy_q & fwd & sw_rd;
	assign sw_rdata       = loc_rd_q ? loc_rdata_q : link.reg_rdata;
	assign host_ready     = ready_q;

	// Power-up wait covers the device's own calibration
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			wait_q  <= 16'(WAIT_CYCLES - 1);
			ready_q <= 1'b0;
		end
		else if (!ready_q)
		begin
			wait_q  <= wait_q - 16'h0001;
			ready_q <= wait_done;
		end
	end

	// Local registers and sequence engine
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			pin_q       <= 1'b0;
			seq_busy_q  <= 1'b0;
			seq_idx_q   <= 2'h0;
			seq_end_q   <= 2'h0;
			loc_rd_q    <= 1'b0;
			loc_rdata_q <= 8'h00;
		end
		else
		begin
			loc_rd_q    <= sw_rd & local_hit;
			loc_rdata_q <= (sw_rd & local_hit) ? loc_val : 8'h00;
			if (sw_wr && sw_addr == ACC_HREG_PIN && ready_q)
				pin_q <= sw_wdata[0];
			if (seq_busy_q)
			begin
				seq_idx_q  <= seq_idx_q + 2'h1;
				seq_busy_q <= (seq_idx_q != seq_end_q);
			end
			else if (!ready_q && wait_done)
			begin
				seq_busy_q <= 1'b1;
				seq_idx_q  <= 2'h0;
				seq_end_q  <= 2'h1;
			end
			else if (cmd_wr && sw_wdata[ACC_BIT_CMD_BG])
			begin
				seq_busy_q <= 1'b1;
				seq_idx_q  <= 2'h2;
				seq_end_q  <= 2'h3;
			end
			else if (cmd_wr && sw_wdata[ACC_BIT_CMD_SWAP])
			begin
				seq_busy_q <= 1'b1;
				seq_idx_q  <= 2'h0;
				seq_end_q  <= 2'h1;
			end
		end
	end
endmodule

// *** dv/acc_assertions.sv ***
`timescale 1ns/10ps
module acc_assertions
	import acc_pkg::*;
#(
	parameter int FG_CYCLES = ACC_FG_CAL_CYC
)(
	input  wire logic       ref_clk,
	input  wire logic       reset,
	input  wire logic       external_cal_trigger_pin,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_rdata
);
	logic [15:0] cyc_q;
	logic        wr_seen_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// Cycles since reset, saturating so a long run cannot wrap back under the limit
	always_ff @(posedge ref_clk)
	begin
		cyc_q     <= reset ? 16'h0000 : cyc_q + {15'h0000, cyc_q != 16'hFFFF};
		wr_seen_q <= !reset && (wr_seen_q || reg_wr);
	end

	a_no_dual_strobe: assert property (!(reg_wr && reg_rd))
		else $error("write and read strobes together");
	a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read answer cycle");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_status_reserved: assert property (reg_rd && reg_addr == ACC_REG_STATUS |=> !reg_rdata[7] && !reg_rdata[3])
		else $error("status reserved bits set");
	a_no_early_access: assert property (reg_wr || reg_rd |-> cyc_q >= FG_CYCLES)
		else $error("device accessed during power-up calibration");
	a_no_early_pin: assert property (external_cal_trigger_pin |-> cyc_q >= FG_CYCLES)
		else $error("trigger pin raised during power-up calibration");
	a_first_write_src: assert property (reg_wr && !wr_seen_q |-> reg_addr == ACC_REG_SWAP_SRC && reg_wdata == ACC_REC_SWAP_SRC)
		else $error("first write is not the swap source delay");
	a_swap_mux_follow: assert property (reg_wr && reg_addr == ACC_REG_SWAP_SRC && reg_wdata == ACC_REC_SWAP_SRC
		|=> reg_wr && reg_addr == ACC_REG_SWAP_MUX && reg_wdata == ACC_REC_SWAP_MUX)
		else $error("swap mux delay write missing");
	a_bg_start_order: assert property (reg_wr && reg_addr == ACC_REG_CAL_CTRL && reg_wdata == ACC_BG_CTRL_VAL
		|-> ##[1:3] (reg_wr && reg_addr == ACC_REG_TRIG && reg_wdata == ACC_BG_TRIG_VAL))
		else $error("background trigger write missing");
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench
	import acc_pkg::*;
;
	localparam int FG = 20;
	localparam int HOME [4] = '{0, 1, 4, 5};
	localparam int SPARE [4] = '{2, 2, 3, 3};
	logic                                ref_clk;
	logic                                reset;
	logic [7:0]                          sw_addr;
	logic [7:0]                          sw_wdata;
	logic                                sw_wr;
	logic                                sw_rd;
	logic [7:0]                          sw_rdata;
	logic                                host_ready;
	logic [ACC_NUM_CORES-1:0][11:0]      core_sample;
	logic [ACC_NUM_CHANS-1:0][11:0]      chan_data;
	logic [5:0]                          core_sampling;
	logic [5:0]                          core_in_cal;
	logic                                fg_ofs;
	logic                                bg_ofs;
	logic                                cal_busy;
	logic [5:0]                          cal_mask;
	logic                                mon;
	int                                  err_total;
	int                                  n_tests;
	int                                  fg_cnt;
	int                                  bg_cnt;
	int                                  busy_cnt;
	int                                  bad;
	int                                  cyc;

	acc_link_if link();
	acc_dev #(.FG_CAL_CYCLES(FG), .BG_CAL_CYCLES(10)) i_acc_dev (.ref_clk(ref_clk), .reset(reset), .link(link),
		.core_sample(core_sample), .chan_data(chan_data), .core_sampling(core_sampling), .core_in_cal(core_in_cal),
		.fg_offset_correction(fg_ofs), .bg_offset_correction(bg_ofs), .cal_busy(cal_busy));
	acc_host #(.WAIT_CYCLES(30)) i_acc_host (.ref_clk(ref_clk), .reset(reset), .link(link), .sw_addr(sw_addr),
		.sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .host_ready(host_ready));
	acc_assertions #(.FG_CYCLES(FG)) i_acc_assertions (.ref_clk(ref_clk), .reset(reset),
		.external_cal_trigger_pin(link.external_cal_trigger_pin), .reg_addr(link.reg_addr),
		.reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata));

	always #5 ref_clk = ~ref_clk;

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sw_addr  <= a;
		sw_wdata <= d;
		sw_wr    <= 1'b1;
		@(posedge ref_clk);
		sw_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge ref_clk);
		sw_addr <= a;
		sw_rd   <= 1'b1;
		@(posedge ref_clk);
		sw_rd <= 1'b0;
		#1;
		chk({4'h0, sw_rdata & m}, {4'h0, e});
	endtask

	// Bounded wait; a hang here shows up as a failed compare, not a stuck run
	task automatic wait_busy(input logic v);
		for (int i = 0; i < 200 && cal_busy !== v; i++)
			@(posedge ref_clk);
		#1;
	endtask

	// Pulse counters, background monitor and run-time ceiling
	always @(posedge ref_clk)
	begin
		cyc++;
		fg_cnt   += int'(fg_ofs === 1'b1);
		bg_cnt   += int'(bg_ofs === 1'b1);
		busy_cnt += int'(cal_busy === 1'b1);
		if (mon)
		begin
			cal_mask |= core_in_cal;
			bad += int'(!$onehot0(core_in_cal) || cal_busy !== 1'b0);
			for (int c = 0; c < 4; c++)
				bad += int'(chan_data[c] !== 12'(12'h100 + HOME[c]) && chan_data[c] !== 12'(12'h100 + SPARE[c]));
		end
		if (cyc == 8000)
		begin
			err_total++;
			tally_and_finish;
		end
	end

	initial
	begin
		ref_clk  = 1'b0;
		reset    = 1'b1;
		sw_addr  = 8'h00;
		sw_wdata = 8'h00;
		sw_wr    = 1'b0;
		sw_rd    = 1'b0;
		mon      = 1'b0;
		cal_mask = 6'h00;
		// Core codes kept well away from the zero code while offset correction runs
		for (int k = 0; k < ACC_NUM_CORES; k++)
			core_sample[k] = 12'(12'h100 + k);
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		rchk(ACC_HREG_STATUS, 8'h00, 8'hFF);
		chk({11'h000, cal_busy}, 12'h001);
		rchk(ACC_REG_STATUS, 8'h00, 8'hFF);
		for (int i = 0; i < 100 && host_ready !== 1'b1; i++)
			@(posedge ref_clk);
		repeat (4) @(posedge ref_clk);
		rchk(ACC_HREG_STATUS, 8'h01, 8'hFF);
		rchk(ACC_REG_STATUS, 8'h01, 8'h07);
		chk({6'h00, core_sampling}, 12'h033);
		for (int c = 0; c < 4; c++)
			chk(chan_data[c], 12'(12'h100 + HOME[c]));
		rchk(ACC_REG_SWAP_SRC, ACC_REC_SWAP_SRC, 8'hFF);
		rchk(ACC_REG_SWAP_MUX, ACC_REC_SWAP_MUX, 8'hFF);
		wr(ACC_REG_SWAP_SRC, 8'h55);
		rchk(ACC_REG_SWAP_SRC, 8'h55, 8'hFF);
		wr(ACC_HREG_CMD, 8'h02);
		repeat (4) @(posedge ref_clk);
		rchk(ACC_REG_SWAP_SRC, ACC_REC_SWAP_SRC, 8'hFF);
		// Factory trims read back and are writable; a hole reads zero and status ignores writes
		rchk(ACC_REG_OFS_BASE, ACC_TRIM_DEFAULT, 8'hFF);
		rchk(ACC_REG_GAIN_BASE + 8'h05, ACC_TRIM_DEFAULT, 8'hFF);
		rchk(ACC_REG_TERM_BASE + 8'h03, ACC_TRIM_DEFAULT, 8'hFF);
		wr(ACC_REG_OFS_BASE + 8'h02, 8'h33);
		rchk(ACC_REG_OFS_BASE + 8'h02, 8'h33, 8'hFF);
		rchk(8'h00, 8'h00, 8'hFF);
		wr(ACC_REG_STATUS, 8'hFE);
		rchk(ACC_REG_STATUS, 8'h01, 8'h07);
		// Software-triggered foreground with offset correction, plus a retrigger mid-run
		wr(ACC_REG_CAL_CTRL, 8'h02);
		wr(ACC_REG_TRIG, 8'h00);
		fg_cnt   = 0;
		busy_cnt = 0;
		wr(ACC_REG_TRIG, 8'h02);
		repeat (3) @(posedge ref_clk);
		#1;
		chk({11'h000, cal_busy}, 12'h001);
		chk({6'h00, core_in_cal}, 12'h03F);
		for (int c = 0; c < 4; c++)
			chk(chan_data[c], ACC_MID_CODE);
		rchk(ACC_REG_STATUS, 8'h02, 8'h03);
		wr(ACC_REG_TRIG, 8'h00);
		wr(ACC_REG_TRIG, 8'h02);
		wait_busy(1'b0);
		repeat (10) @(posedge ref_clk);
		chk({11'h000, cal_busy}, 12'h000);
		chk(12'(busy_cnt >= FG && busy_cnt <= FG + 2), 12'h001);
		chk(12'(fg_cnt), 12'h001);
		rchk(ACC_REG_STATUS, 8'h01, 8'h03);
		// Pin selected: a software edge is ignored, a pin edge starts calibration
		wr(ACC_REG_TRIG, 8'h01);
		wr(ACC_REG_TRIG, 8'h03);
		repeat (8) @(posedge ref_clk);
		chk({11'h000, cal_busy}, 12'h000);
		wr(ACC_HREG_PIN, 8'h01);
		repeat (6) @(posedge ref_clk);
		#1;
		chk({11'h000, cal_busy}, 12'h001);
		wait_busy(1'b0);
		wr(ACC_HREG_PIN, 8'h00);
		// Background rotation: output never stops, one core at a time
		wr(ACC_REG_CAL_CTRL, 8'h00);
		wr(ACC_REG_TRIG, 8'h00);
		wr(ACC_HREG_CMD, 8'h01);
		repeat (6) @(posedge ref_clk);
		wr(ACC_REG_CAL_CTRL, 8'h05);
		bg_cnt = 0;
		mon    = 1'b1;
		repeat (1500) @(posedge ref_clk);
		mon = 1'b0;
		chk(12'(bad), 12'h000);
		chk({6'h00, cal_mask}, 12'h03F);
		chk(12'(bg_cnt >= 6), 12'h001);
		rchk(ACC_REG_STATUS, 8'h05, 8'h07);
		wr(ACC_REG_CAL_CTRL, 8'h00);
		for (int i = 0; i < 500 && core_sampling !== 6'h33; i++)
			@(posedge ref_clk);
		chk({6'h00, core_sampling}, 12'h033);
		tally_and_finish;
	end
endmodule
